/* File: dv/pll_power_osc_trim_control_tb_top.sv */
// Testbench: register-level tests of the clock, power and trim block
module pll_power_osc_trim_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hF;
    logic wake_event = 1'b0;
    logic cal_target_lp = 1'b1;
    logic [18:0] mbc = 19'h0;
    logic pready, pslverr, pll_src_sel, pll_power_en, core_power_en, periph_power_en, prec_osc_en, pll_locked;
    logic baud_in_range;
    logic [31:0] prdata, lp_trim, prec_trim, rdv;
    logic [2:0] core_clock_divider;
    logic erv;
    int fail_count = 0;
    int samples_checked = 0;

    // Short lock count keeps the relock waits brief
    pptc_top #(.LOCK_CYCLES(20)) dut (.clock(clock), .rst_n(rst_n), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .wake_event(wake_event), .cal_target_lp(cal_target_lp), .measured_baud_count(mbc),
        .pll_src_sel(pll_src_sel), .pll_power_en(pll_power_en), .core_power_en(core_power_en),
        .periph_power_en(periph_power_en), .prec_osc_en(prec_osc_en), .pll_locked(pll_locked),
        .core_clock_divider(core_clock_divider), .lp_trim(lp_trim), .prec_trim(prec_trim),
        .baud_in_range(baud_in_range));

    // 40 MHz clock
    initial begin
        forever #12.5 clock = ~clock;
    end

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge clock);
    endtask

    // One APB transfer; an idle cycle follows so psel is never driven twice in one step
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge clock);
            n++;
        end
        rdv = prdata;
        erv = pslverr;
        if (n >= 20) chk(32'h0, 32'h1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rdv, e);
    endtask

    // Prewrite key, value, postwrite key, then time for the value to land
    task automatic keyed(input logic [31:0] k0, input logic [31:0] a, input logic [31:0] v, input logic [31:0] k1);
        wr(k0, 32'h0 | (k0 == pptc_pkg::ADDR_PLL_KEY0 ? pptc_pkg::PLL_KEY0 : pptc_pkg::POW_KEY0));
        wr(a, v);
        wr(k1, 32'h0 | (k1 == pptc_pkg::ADDR_PLL_KEY1 ? pptc_pkg::PLL_KEY1 : pptc_pkg::POW_KEY1));
        cyc(3);
    endtask

    task automatic wlock();
        int n;
        n = 0;
        while (pll_locked !== 1'b1 && n < 60) begin
            @(posedge clock);
            n++;
        end
        chk({31'h0, pll_locked}, 32'h1);
    endtask

    function automatic logic [31:0] pwr();
        return {28'h0, pll_power_en, periph_power_en, core_power_en, prec_osc_en};
    endfunction

    // Watchdog: the whole sequence needs well under 3000 cycles
    initial begin
        repeat (20000) @(posedge clock);
        fail_count++;
        print_verdict();
    end

    // Main sequence
    initial begin
        logic [31:0] bv [4];
        logic [31:0] be [4];
        bv = '{32'hFF, 32'h100, 32'h200, 32'h201};
        be = '{32'h0, 32'h1, 32'h1, 32'h0};
        cyc(8);
        rst_n <= 1'b1;
        cyc(4);
        rd(pptc_pkg::ADDR_PLL_CON, 32'h0);
        rd(pptc_pkg::ADDR_POW_CON, 32'h139);
        rd(pptc_pkg::ADDR_BAUD_MAX, 32'h0);
        rd(pptc_pkg::ADDR_BAUD_MIN, 32'h0);
        rd(pptc_pkg::ADDR_CAL_STA, 32'h1);
        rd(32'hFFFF0500, 32'h0);
        chk({31'h0, erv}, 32'h1);
        wlock();
        rd(pptc_pkg::ADDR_PLL_STA, 32'h2);
        chk({29'h0, core_clock_divider}, 32'h1);
        // Every divider code through the keyed power write
        for (int cd = 0; cd < 8; cd++) begin
            keyed(pptc_pkg::ADDR_POW_KEY0, pptc_pkg::ADDR_POW_CON, 32'h138 | cd, pptc_pkg::ADDR_POW_KEY1);
            chk({29'h0, core_clock_divider}, cd);
        end
        wr(pptc_pkg::ADDR_POW_KEY0, pptc_pkg::POW_KEY0);
        wr(pptc_pkg::ADDR_LP_USR, 32'h5);
        wr(pptc_pkg::ADDR_POW_CON, 32'h139);
        wr(pptc_pkg::ADDR_POW_KEY1, pptc_pkg::POW_KEY1);
        rd(pptc_pkg::ADDR_POW_CON, 32'h13F);
        wr(pptc_pkg::ADDR_POW_KEY0, pptc_pkg::POW_KEY0);
        wr(pptc_pkg::ADDR_POW_CON, 32'h139);
        wr(pptc_pkg::ADDR_POW_KEY1, pptc_pkg::PLL_KEY1);
        rd(pptc_pkg::ADDR_POW_CON, 32'h13F);
        keyed(pptc_pkg::ADDR_PLL_KEY0, pptc_pkg::ADDR_PLL_CON, 32'h1, pptc_pkg::ADDR_PLL_KEY1);
        chk({31'h0, pll_src_sel}, 32'h1);
        wlock();
        wr(pptc_pkg::ADDR_PLL_STA, 32'h0);
        rd(pptc_pkg::ADDR_PLL_STA, 32'h3);
        wr(pptc_pkg::ADDR_PLL_STA, 32'h1);
        rd(pptc_pkg::ADDR_PLL_STA, 32'h2);
        // Back to the low power oscillator, then full power-down in one write and a wake-up
        keyed(pptc_pkg::ADDR_PLL_KEY0, pptc_pkg::ADDR_PLL_CON, 32'h0, pptc_pkg::ADDR_PLL_KEY1);
        chk({31'h0, pll_src_sel}, 32'h0);
        keyed(pptc_pkg::ADDR_POW_KEY0, pptc_pkg::ADDR_POW_CON, 32'h0, pptc_pkg::ADDR_POW_KEY1);
        chk(pwr(), 32'h0);
        wake_event <= 1'b1;
        cyc(8);
        chk(pwr(), 32'hE);
        rd(pptc_pkg::ADDR_POW_CON, 32'h38);
        wake_event <= 1'b0;
        wlock();
        rd(pptc_pkg::ADDR_PLL_STA, 32'h3);
        // Trims stay locked until the unlock key
        wr(pptc_pkg::ADDR_LP_USR, 32'h1234);
        rd(pptc_pkg::ADDR_LP_VAL, 32'h0);
        wr(pptc_pkg::ADDR_CAL_KEY, pptc_pkg::CAL_KEY);
        wr(pptc_pkg::ADDR_LP_USR, 32'hABCD);
        rd(pptc_pkg::ADDR_LP_VAL, 32'hABCD);
        chk(lp_trim, 32'hABCD);
        rd(pptc_pkg::ADDR_CAL_STA, 32'h5);
        rd(pptc_pkg::ADDR_CAL_STA, 32'h1);
        wr(pptc_pkg::ADDR_PR_USR, 32'h77);
        chk(prec_trim, 32'h77);
        rd(pptc_pkg::ADDR_CAL_STA, 32'h3);
        wr(pptc_pkg::ADDR_LP_VAL, 32'hFFFF);
        rd(pptc_pkg::ADDR_LP_VAL, 32'hABCD);
        cal_target_lp <= 1'b0;
        cyc(5);
        rd(pptc_pkg::ADDR_CAL_STA, 32'h0);
        // Limits bracket the measured count at both edges
        wr(pptc_pkg::ADDR_BAUD_MAX, 32'h200);
        wr(pptc_pkg::ADDR_BAUD_MIN, 32'h100);
        rd(pptc_pkg::ADDR_BAUD_MAX, 32'h200);
        for (int i = 0; i < 4; i++) begin
            mbc <= bv[i][18:0];
            cyc(3);
            chk({31'h0, baud_in_range}, be[i]);
        end
        // Clock enable low freezes the compare; it catches up once enabled
        ce <= 1'b0;
        mbc <= 19'h00180;
        cyc(3);
        chk({31'h0, baud_in_range}, 32'h0);
        ce <= 1'b1;
        cyc(3);
        chk({31'h0, baud_in_range}, 32'h1);
        print_verdict();
    end
endmodule

/* File: dv/pptc_top_asserts.sv */
// Checker for the bus, lock, wake and divider behaviour at the block's ports
module pptc_top_asserts #(
    parameter int LOCK_CYCLES = pptc_pkg::PLL_LOCK_CYC
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic wake_event,
    input wire logic pll_src_sel,
    input wire logic pll_power_en,
    input wire logic core_power_en,
    input wire logic periph_power_en,
    input wire logic pll_locked,
    input wire logic [2:0] core_clock_divider
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    logic [31:0] unl_q;

    // Cycles spent powered but unlocked; a restart inside this span only lengthens it
    always_ff @(posedge clock) begin
        if (!rst_n || pll_locked || !pll_power_en) begin
            unl_q <= 32'h0;
        end else if (ce) begin
            unl_q <= unl_q + 32'h1;
        end
    end

    sequence s_setup;
        psel && !penable && ce;
    endsequence
    sequence s_wait;
        psel && penable && !pready && ce;
    endsequence

    a_apb_wait: assert property (s_setup ##1 s_wait |=> pready) else $error("no answer in 2nd access cycle");
    a_ready_pulse: assert property (pready |=> !pready) else $error("pready longer than one cycle");
    a_err_zero: assert property (pslverr |-> pready && prdata == 32'h0) else $error("error without zero data");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0) else $error("read data outside answer");
    a_lock_early: assert property ($rose(pll_locked) |-> unl_q >= LOCK_CYCLES - 2) else $error("lock too soon");
    a_lock_late: assert property (unl_q <= LOCK_CYCLES + 8) else $error("lock too late");
    a_pll_off: assert property ($fell(pll_power_en) |-> ##[0:3] !pll_locked) else $error("lock kept unpowered");
    a_wake_power: assert property ($rose(wake_event) |-> ##[1:6] (pll_power_en && core_power_en && periph_power_en))
        else $error("wake left power off");
    a_src_relock: assert property ($changed(pll_src_sel) |-> ##[0:3] !pll_locked) else $error("no relock");
    a_div_unlock: assert property (!pll_locked [*3] |-> core_clock_divider == 3'h3) else $error("not div 8");
endmodule

bind pptc_top pptc_top_asserts #(.LOCK_CYCLES(LOCK_CYCLES)) u_chk (.clock(clock), .rst_n(rst_n), .ce(ce),
    .psel(psel), .penable(penable), .pready(pready), .prdata(prdata), .pslverr(pslverr), .wake_event(wake_event),
    .pll_src_sel(pll_src_sel), .pll_power_en(pll_power_en), .core_power_en(core_power_en),
    .periph_power_en(periph_power_en), .pll_locked(pll_locked), .core_clock_divider(core_clock_divider));

/* File: src/pptc_key_gate.sv */
// Keyed write sequencer: prewrite key, value, postwrite key
module pptc_key_gate #(
    parameter logic [31:0] KEY_PRE = 32'h00000000,
    parameter logic [31:0] KEY_POST = 32'h00000000,
    parameter logic [31:0] RESET_VAL = 32'h00000000
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic wr,
    input wire logic full_word,
    input wire logic hit_pre,
    input wire logic hit_val,
    input wire logic hit_post,
    input wire logic [31:0] wdata,
    output logic commit,
    output logic [31:0] value
);

    pptc_pkg::pptc_key_st_t q, d;

    // Any write that breaks the sequence, except the prewrite key which re-arms, drops back to idle and keeps the value
    always_comb begin
        d = q;
        d.commit = 1'b0;
        if (wr) begin
            if (hit_pre && full_word && wdata == KEY_PRE) begin
                d.state = pptc_pkg::KEY_ARMED;
            end else if (q.state == pptc_pkg::KEY_ARMED && hit_val) begin
                d.state = pptc_pkg::KEY_HELD;
                d.pend = wdata;
            end else if (q.state == pptc_pkg::KEY_HELD && hit_post && full_word && wdata == KEY_POST) begin
                d.state = pptc_pkg::KEY_IDLE;
                d.value = q.pend;
                d.commit = 1'b1;
            end else begin
                d.state = pptc_pkg::KEY_IDLE;
            end
        end
    end

    // State register
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            q.state <= pptc_pkg::KEY_IDLE;
            q.pend <= RESET_VAL;
            q.value <= RESET_VAL;
            q.commit <= 1'b0;
        end else if (ce) begin
            q <= d;
        end
    end

    assign commit = q.commit;
    assign value = q.value;

endmodule

/* File: src/pptc_lock_timer.sv */
// PLL lock timer: counts the lock interval after any restart
module pptc_lock_timer #(
    parameter int LOCK_CYCLES = pptc_pkg::PLL_LOCK_CYC
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic pll_on,
    input wire logic restart,
    output logic locked,
    output logic lock_fell
);

    pptc_pkg::pptc_lock_st_t q, d;

    // Lock comes exactly LOCK_CYCLES after the last restart with power on
    always_comb begin
        d = q;
        if (restart || !pll_on) begin
            d.cnt = '0;
            d.locked = 1'b0;
        end else if (!q.locked) begin
            if (q.cnt == 17'(LOCK_CYCLES - 1)) begin
                d.locked = 1'b1;
            end else begin
                d.cnt = q.cnt + 17'h00001;
            end
        end
        d.fell = q.locked && !d.locked;
    end

    // State register
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            q <= '0;
        end else if (ce) begin
            q <= d;
        end
    end

    assign locked = q.locked;
    assign lock_fell = q.fell;

endmodule

/* File: src/pptc_pkg.sv */
// Package: register map, field layout, reset values, timing counts and state carriers
package pptc_pkg;

    // Register byte addresses
    localparam logic [31:0] ADDR_PLL_STA = 32'hFFFF0400;
    localparam logic [31:0] ADDR_POW_KEY0 = 32'hFFFF0404;
    localparam logic [31:0] ADDR_POW_CON = 32'hFFFF0408;
    localparam logic [31:0] ADDR_POW_KEY1 = 32'hFFFF040C;
    localparam logic [31:0] ADDR_PLL_KEY0 = 32'hFFFF0410;
    localparam logic [31:0] ADDR_PLL_CON = 32'hFFFF0414;
    localparam logic [31:0] ADDR_PLL_KEY1 = 32'hFFFF0418;
    localparam logic [31:0] ADDR_LP_USR = 32'hFFFF0484;
    localparam logic [31:0] ADDR_PR_USR = 32'hFFFF0488;
    localparam logic [31:0] ADDR_BAUD_MAX = 32'hFFFF048C;
    localparam logic [31:0] ADDR_BAUD_MIN = 32'hFFFF0490;
    localparam logic [31:0] ADDR_CAL_STA = 32'hFFFF0494;
    localparam logic [31:0] ADDR_LP_VAL = 32'hFFFF0498;
    localparam logic [31:0] ADDR_PR_VAL = 32'hFFFF049C;
    localparam logic [31:0] ADDR_CAL_KEY = 32'hFFFF04A0;

    // Key values
    localparam logic [31:0] PLL_KEY0 = 32'h000000AA;
    localparam logic [31:0] PLL_KEY1 = 32'h00000055;
    localparam logic [31:0] POW_KEY0 = 32'h00000001;
    localparam logic [31:0] POW_KEY1 = 32'h000000F4;
    localparam logic [31:0] CAL_KEY = 32'h00001324;

    // Field positions
    localparam int STA_IRQ = 0;
    localparam int STA_LOCK = 1;
    localparam int POW_CD_LSB = 0;
    localparam int POW_CORE = 3;
    localparam int POW_PERIPH = 4;
    localparam int POW_PLL = 5;
    localparam int POW_PREC_OSC = 8;
    localparam int PLL_SRC_BIT = 0;
    localparam int CAL_TGT = 0;
    localparam int CAL_PR_MOD = 1;
    localparam int CAL_LP_MOD = 2;

    // Writable bits and reset values
    localparam logic [15:0] POW_WMASK = 16'h013F;
    localparam logic [15:0] POW_WAKE_SET = 16'h0038;
    localparam logic [15:0] POW_RESET = 16'h0139;
    localparam logic [7:0] PLL_SEL_RESET = 8'h00;
    localparam logic [2:0] CAL_STA_RESET = 3'h1;
    localparam logic [31:0] TRIM_RESET = 32'h00000000;
    localparam logic [31:0] BAUD_RESET = 32'h00000000;
    localparam logic [2:0] DIV_UNLOCKED = 3'h3;

    // Lock time, counted at the 40 MHz block clock; longest time rounds down
    localparam int CLK_FREQ_KHZ = 40000;
    localparam int PLL_LOCK_TIME_US = 2000;
    localparam int PLL_LOCK_CYC = PLL_LOCK_TIME_US * CLK_FREQ_KHZ / 1000;

    typedef enum logic [1:0] {KEY_IDLE, KEY_ARMED, KEY_HELD} pptc_key_state_t;

    typedef struct packed {
        pptc_key_state_t state;
        logic [31:0] pend;
        logic [31:0] value;
        logic commit;
    } pptc_key_st_t;

    typedef struct packed {
        logic [16:0] cnt;
        logic locked;
        logic fell;
    } pptc_lock_st_t;

    typedef struct packed {
        logic wake_s1;
        logic wake_s2;
        logic wake_prev;
        logic tgt_s1;
        logic tgt_s2;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [7:0] pll_sel;
        logic [15:0] pow;
        logic pll_irq;
        logic cal_unlock;
        logic [2:0] cal_sta;
        logic [31:0] lp_user;
        logic [31:0] pr_user;
        logic [31:0] lp_val;
        logic [31:0] pr_val;
        logic [31:0] baud_max;
        logic [31:0] baud_min;
        logic [2:0] div_exp;
        logic in_range;
    } pptc_top_st_t;

    // Byte-lane merge for APB writes
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

endpackage

/* File: src/pptc_top.sv */
// PLL source, power control, core clock divider and oscillator trim block with APB slave
//
// Local design decision: register access over APB.
module pptc_top #(
    parameter int LOCK_CYCLES = pptc_pkg::PLL_LOCK_CYC
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic wake_event,
    input wire logic cal_target_lp,
    input wire logic [18:0] measured_baud_count,
    output logic pll_src_sel,
    output logic pll_power_en,
    output logic core_power_en,
    output logic periph_power_en,
    output logic prec_osc_en,
    output logic pll_locked,
    output logic [2:0] core_clock_divider,
    output logic [31:0] lp_trim,
    output logic [31:0] prec_trim,
    output logic baud_in_range
);

    pptc_pkg::pptc_top_st_t q, d;

    logic wr_fire;
    logic rd_fire;
    logic full_word;
    logic wake_rise;
    logic pll_commit;
    logic pow_commit;
    logic [31:0] pll_value;
    logic [31:0] pow_value;
    logic locked;
    logic lock_fell;
    logic restart;
    logic [31:0] rd_mux;
    logic rd_hit;
    logic [31:0] lp_next;
    logic [31:0] pr_next;

    // Address hits, one per register; a miss on all of them is an unmapped access
    logic hit_sta;
    logic hit_powk0;
    logic hit_pow;
    logic hit_powk1;
    logic hit_pllk0;
    logic hit_pll;
    logic hit_pllk1;
    logic hit_lpu;
    logic hit_pru;
    logic hit_bmax;
    logic hit_bmin;
    logic hit_csta;
    logic hit_lpv;
    logic hit_prv;
    logic hit_ckey;

    // Lock status
    assign hit_sta = paddr == pptc_pkg::ADDR_PLL_STA;

    // Power control and its keys
    assign hit_powk0 = paddr == pptc_pkg::ADDR_POW_KEY0;
    assign hit_pow = paddr == pptc_pkg::ADDR_POW_CON;
    assign hit_powk1 = paddr == pptc_pkg::ADDR_POW_KEY1;

    // Source select and its keys
    assign hit_pllk0 = paddr == pptc_pkg::ADDR_PLL_KEY0;
    assign hit_pll = paddr == pptc_pkg::ADDR_PLL_CON;
    assign hit_pllk1 = paddr == pptc_pkg::ADDR_PLL_KEY1;

    // Trims, limits and calibration status
    assign hit_lpu = paddr == pptc_pkg::ADDR_LP_USR;
    assign hit_pru = paddr == pptc_pkg::ADDR_PR_USR;
    assign hit_bmax = paddr == pptc_pkg::ADDR_BAUD_MAX;
    assign hit_bmin = paddr == pptc_pkg::ADDR_BAUD_MIN;
    assign hit_csta = paddr == pptc_pkg::ADDR_CAL_STA;
    assign hit_lpv = paddr == pptc_pkg::ADDR_LP_VAL;
    assign hit_prv = paddr == pptc_pkg::ADDR_PR_VAL;
    assign hit_ckey = paddr == pptc_pkg::ADDR_CAL_KEY;

    // A transfer completes at the edge where pready is seen high
    assign wr_fire = psel && penable && q.pready && pwrite;
    assign rd_fire = psel && penable && q.pready && !pwrite;
    assign full_word = pstrb == 4'hF;
    assign wake_rise = q.wake_s2 && !q.wake_prev;

    // Lock restarts on wake and on a committed source change
    // A new source invalidates the old lock, so the timer starts over
    assign restart = wake_rise || pll_commit;

    // Both gates see every write, so any stray write aborts a sequence
    // Keyed source select
    pptc_key_gate #(
        .KEY_PRE(pptc_pkg::PLL_KEY0),
        .KEY_POST(pptc_pkg::PLL_KEY1),
        .RESET_VAL({24'h000000, pptc_pkg::PLL_SEL_RESET})
    ) u_pll_gate (
        .clock(clock),
        .rst_n(rst_n),
        .ce(ce),
        .wr(wr_fire),
        .full_word(full_word),
        .hit_pre(hit_pllk0),
        .hit_val(hit_pll),
        .hit_post(hit_pllk1),
        .wdata(pwdata),
        .commit(pll_commit),
        .value(pll_value)
    );

    // Keyed power and divider control
    pptc_key_gate #(
        .KEY_PRE(pptc_pkg::POW_KEY0),
        .KEY_POST(pptc_pkg::POW_KEY1),
        .RESET_VAL({16'h0000, pptc_pkg::POW_RESET})
    ) u_pow_gate (
        .clock(clock),
        .rst_n(rst_n),
        .ce(ce),
        .wr(wr_fire),
        .full_word(full_word),
        .hit_pre(hit_powk0),
        .hit_val(hit_pow),
        .hit_post(hit_powk1),
        .wdata(pwdata),
        .commit(pow_commit),
        .value(pow_value)
    );

    // Lock interval model
    // Power-off and restart both hold the timer at zero
    pptc_lock_timer #(
        .LOCK_CYCLES(LOCK_CYCLES)
    ) u_lock (
        .clock(clock),
        .rst_n(rst_n),
        .ce(ce),
        .pll_on(q.pow[pptc_pkg::POW_PLL]),
        .restart(restart),
        .locked(locked),
        .lock_fell(lock_fell)
    );

    // Read data mux; unmapped addresses answer with an error and zero
    // Reads never abort a key sequence, so polling is safe mid-sequence
    always_comb begin
        rd_mux = 32'h00000000;
        rd_hit = 1'b1;
        if (hit_sta) begin
            rd_mux[pptc_pkg::STA_LOCK] = locked;
            rd_mux[pptc_pkg::STA_IRQ] = q.pll_irq;
        end else if (hit_pow) begin
            rd_mux[15:0] = q.pow;
        end else if (hit_pll) begin
            rd_mux[7:0] = q.pll_sel;
        end else if (hit_lpu) begin
            rd_mux = q.lp_user;
        end else if (hit_pru) begin
            rd_mux = q.pr_user;
        end else if (hit_bmax) begin
            rd_mux = q.baud_max;
        end else if (hit_bmin) begin
            rd_mux = q.baud_min;
        end else if (hit_csta) begin
            rd_mux[2:0] = q.cal_sta;
        end else if (hit_lpv) begin
            rd_mux = q.lp_val;
        end else if (hit_prv) begin
            rd_mux = q.pr_val;
        end else if (hit_powk0 || hit_powk1 || hit_pllk0 || hit_pllk1 || hit_ckey) begin
            rd_mux = 32'h00000000; // Write-only keys read as zero
        end else begin
            rd_hit = 1'b0;
        end
    end

    // Candidate trim values, taken only while calibration is unlocked
    assign lp_next = pptc_pkg::merge(q.lp_user, pwdata, pstrb);
    assign pr_next = pptc_pkg::merge(q.pr_user, pwdata, pstrb);

    // Next-state logic for the whole block
    always_comb begin
        d = q;

        // The wake and target pin inputs pass two flip-flops before use; measured_baud_count goes straight to the compare
        // A single flop could pass a metastable wake level into the logic
        d.wake_s1 = wake_event;
        d.wake_s2 = q.wake_s1;
        d.wake_prev = q.wake_s2;
        d.tgt_s1 = cal_target_lp;
        d.tgt_s2 = q.tgt_s1;

        // APB: one wait cycle, then pready for one cycle
        // The wait cycle lets prdata leave a flop, at one cycle of latency
        d.pready = psel && penable && !q.pready;
        if (psel && penable && !q.pready) begin
            d.prdata = pwrite ? 32'h00000000 : rd_mux;
            d.pslverr = !rd_hit;
        end else begin
            d.prdata = 32'h00000000;
            d.pslverr = 1'b0;
        end

        // Source select only follows a complete key sequence
        if (pll_commit) begin
            d.pll_sel = pll_value[7:0];
        end

        // Power control: keyed commit, then wake sets power bits (set wins)
        if (pow_commit) begin
            d.pow = pow_value[15:0] & pptc_pkg::POW_WMASK;
        end
        if (wake_rise) begin
            d.pow = d.pow | pptc_pkg::POW_WAKE_SET;
        end

        // Lock-loss flag: hardware set beats a same-cycle write-one clear
        // Otherwise a lock loss during the clear would go unseen
        if (wr_fire && hit_sta && pstrb[0] && pwdata[pptc_pkg::STA_IRQ]) begin
            d.pll_irq = 1'b0;
        end
        if (lock_fell) begin
            d.pll_irq = 1'b1;
        end

        // Calibration unlock: right key opens, any other key value closes
        // Unlock stays open until software writes another key value
        if (wr_fire && hit_ckey) begin
            d.cal_unlock = full_word && pwdata == pptc_pkg::CAL_KEY;
        end

        // Read of calibration status clears the modified flags
        if (rd_fire && hit_csta) begin
            d.cal_sta[pptc_pkg::CAL_LP_MOD] = 1'b0;
            d.cal_sta[pptc_pkg::CAL_PR_MOD] = 1'b0;
        end

        // User trims are key protected; a changed trim raises its flag
        // Byte-lane merge keeps untouched bytes of a partial trim write
        if (wr_fire && hit_lpu && q.cal_unlock) begin
            d.lp_user = lp_next;
            d.lp_val = lp_next;
            if (lp_next != q.lp_val) begin
                d.cal_sta[pptc_pkg::CAL_LP_MOD] = 1'b1;
            end
        end
        if (wr_fire && hit_pru && q.cal_unlock) begin
            d.pr_user = pr_next;
            d.pr_val = pr_next;
            if (pr_next != q.pr_val) begin
                d.cal_sta[pptc_pkg::CAL_PR_MOD] = 1'b1;
            end
        end

        // Target oscillator follows the synchronised input
        d.cal_sta[pptc_pkg::CAL_TGT] = q.tgt_s2;

        // Baud limits are plain read/write
        if (wr_fire && hit_bmax) begin
            d.baud_max = pptc_pkg::merge(q.baud_max, pwdata, pstrb);
        end
        if (wr_fire && hit_bmin) begin
            d.baud_min = pptc_pkg::merge(q.baud_min, pwdata, pstrb);
        end
        // Registered compare: baud_in_range lags the count by one cycle
        d.in_range = {13'h0000, measured_baud_count} >= q.baud_min
            && {13'h0000, measured_baud_count} <= q.baud_max;

        // Divide-by-8 fallback until lock, then the programmed divider
        // Registered so the divider code never glitches on a lock change
        d.div_exp = locked ? q.pow[pptc_pkg::POW_CD_LSB +: 3] : pptc_pkg::DIV_UNLOCKED;
    end

    // State register; the clock enable freezes everything
    // Synchronous reset only, so the clock must run during reset
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            q <= '0;
            q.tgt_s1 <= 1'b1;
            q.tgt_s2 <= 1'b1;
            q.pll_sel <= pptc_pkg::PLL_SEL_RESET;
            q.pow <= pptc_pkg::POW_RESET;
            q.cal_sta <= pptc_pkg::CAL_STA_RESET;
            q.lp_user <= pptc_pkg::TRIM_RESET;
            q.pr_user <= pptc_pkg::TRIM_RESET;
            q.lp_val <= pptc_pkg::TRIM_RESET;
            q.pr_val <= pptc_pkg::TRIM_RESET;
            q.baud_max <= pptc_pkg::BAUD_RESET;
            q.baud_min <= pptc_pkg::BAUD_RESET;
            q.div_exp <= pptc_pkg::DIV_UNLOCKED;
        end else if (ce) begin
            q <= d;
        end
    end

    // Outputs straight from flops
    // Reserved power bits never reach a pin
    assign pready = q.pready;
    assign prdata = q.prdata;
    assign pslverr = q.pslverr;
    assign pll_src_sel = q.pll_sel[pptc_pkg::PLL_SRC_BIT];
    assign pll_power_en = q.pow[pptc_pkg::POW_PLL];
    assign core_power_en = q.pow[pptc_pkg::POW_CORE];
    assign periph_power_en = q.pow[pptc_pkg::POW_PERIPH];
    assign prec_osc_en = q.pow[pptc_pkg::POW_PREC_OSC];
    assign pll_locked = locked;
    assign core_clock_divider = q.div_exp;
    assign lp_trim = q.lp_val;
    assign prec_trim = q.pr_val;
    assign baud_in_range = q.in_range;

endmodule
